// File: acmc_control.sv
// control word, mode decoder and calibration sequencer of the converter
// assumes the filter pulses measValid once per result for measSrc
//
// Overview of operation
// - mode 000 runs normal conversions and a high-select read returns data.
// - mode 001 self-calibrates the selected channel, then clears the mode.
// - data-ready falls after self-calibration once a valid result is held.
// - self-calibration measures zero on shorted inputs, full on reference.
// - mode 010 zero-calibrates on the input channel, then returns to normal.
// - mode 011 full-calibrates on the input channel, then returns to normal.
// - mode 100 takes zero from the input, full from the reference.
// - mode 101 interleaves calibration, one word per six measurements.
// - background mode refreshes the coefficients with no host action.
// - mode 110 maps high-select transfers onto the zero coefficient.
// - mode 111 maps high-select transfers onto the full coefficient.
// - coefficient transfers are 24 bits and short writes are dropped.
// - low-select transfers reach the control word, 24 bits, extras ignored.
// - data-ready falls on a new word and rises after it is shifted out.
`timescale 1ns/1ns
`default_nettype none
module acmc_control (
    input wire logic clk, // 100 MHz clock
    input wire logic rst, // async reset, high
    input wire logic sclk, // serial clock pin
    input wire logic sdataIn, // serial data pin, input side
    output logic sdataOut, // serial data pin, output side
    output logic sdataOeN, // low while driving serial data
    input wire logic txFrameSyncN, // write frame, low active
    input wire logic rxFrameSyncN, // read frame, low active
    input wire logic registerSelect, // low: control word, high: data/coef
    output logic dataReadyN, // low: new word waiting
    input wire logic measValid, // filter result pulse
    input wire logic [23:0] measData, // filter result
    output acmc_pkg::acmc_src_t measSrc, // what the modulator looks at
    output logic measChannel, // selected input channel
    output logic [23:0] ctrlWord // control word to the analog side
);
    typedef struct packed {
        logic [23:0] ctrl;
        logic [1:0][23:0] zeroCoef;
        logic [1:0][23:0] fullCoef;
        logic [23:0] dataOut;
        logic [23:0] shift;
        logic [4:0] bitCnt;
        logic [4:0] txLen;
        logic rxAct;
        logic txAct;
        logic txData;
        logic readyN;
        acmc_pkg::acmc_phase_t phase;
        logic [2:0] bgSlot;
        logic prevSclk;
        logic prevTfsN;
        logic prevRfsN;
    } acmc_state_t;
    acmc_state_t s_reg, s_next;

    logic [4:0] pins;
    logic sclkS, sdataS, tfsS, rfsS, selS;
    logic ctrlLoad, coefLoad, calDone, publish, txDone;
    logic [2:0] mode, newMode;
    logic ch;

    function automatic acmc_pkg::acmc_phase_t startPhase(logic [2:0] m);
        unique case (m)
            acmc_pkg::MODE_SELF, acmc_pkg::MODE_SYS_ZERO,
            acmc_pkg::MODE_OFFSET: startPhase = acmc_pkg::PH_ZERO;
            acmc_pkg::MODE_SYS_FULL: startPhase = acmc_pkg::PH_FULL;
            default: startPhase = acmc_pkg::PH_CONV;
        endcase
    endfunction

    function automatic acmc_pkg::acmc_src_t srcFor(
        acmc_pkg::acmc_phase_t ph, logic [2:0] m, logic [2:0] slot);
        srcFor = acmc_pkg::SRC_INPUT;
        if (ph == acmc_pkg::PH_ZERO && m == acmc_pkg::MODE_SELF) begin
            srcFor = acmc_pkg::SRC_SHORT;
        end else if (ph == acmc_pkg::PH_FULL && m != acmc_pkg::MODE_SYS_FULL) begin
            srcFor = acmc_pkg::SRC_REF;
        end else if (ph == acmc_pkg::PH_CONV
                && m == acmc_pkg::MODE_BACKGROUND && slot < 3'h2) begin
            srcFor = (slot == 3'h0) ? acmc_pkg::SRC_SHORT : acmc_pkg::SRC_REF;
        end
    endfunction

    acmc_pin_sync #(.W(5), .RST_VAL(acmc_pkg::PIN_RESET)) u_sync (
        .clk(clk),
        .rst(rst),
        .pinIn({sclk, sdataIn, txFrameSyncN, rxFrameSyncN, registerSelect}),
        .pinStable(pins)
    );
    assign {sclkS, sdataS, tfsS, rfsS, selS} = pins;
    assign mode = s_reg.ctrl[acmc_pkg::MODE_HI:acmc_pkg::MODE_LO];
    assign newMode = s_reg.shift[acmc_pkg::MODE_HI:acmc_pkg::MODE_LO];
    assign ch = s_reg.ctrl[acmc_pkg::CH_BIT];

    always_comb begin
        s_next = s_reg;
        ctrlLoad = 1'b0;
        coefLoad = 1'b0;
        calDone = 1'b0;
        publish = 1'b0;
        txDone = 1'b0;
        s_next.prevSclk = sclkS;
        s_next.prevTfsN = tfsS;
        s_next.prevRfsN = rfsS;
        // measurement results steer coefficients or the data register
        if (measValid) begin
            unique case (s_reg.phase)
                acmc_pkg::PH_ZERO: begin
                    s_next.zeroCoef[ch] = measData;
                    if (mode == acmc_pkg::MODE_SYS_ZERO) begin
                        calDone = 1'b1;
                    end else begin
                        s_next.phase = acmc_pkg::PH_FULL;
                    end
                end
                acmc_pkg::PH_FULL: begin
                    s_next.fullCoef[ch] = measData;
                    calDone = 1'b1;
                end
                acmc_pkg::PH_CONV: begin
                    if (mode == acmc_pkg::MODE_BACKGROUND) begin
                        if (s_reg.bgSlot == 3'h0) begin
                            s_next.zeroCoef[ch] = measData;
                        end else if (s_reg.bgSlot == 3'h1) begin
                            s_next.fullCoef[ch] = measData;
                        end
                        publish = (s_reg.bgSlot == acmc_pkg::BG_LAST);
                        s_next.bgSlot = publish ? 3'h0 : s_reg.bgSlot + 3'h1;
                    end else begin
                        publish = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        if (calDone) begin
            s_next.ctrl[acmc_pkg::MODE_HI:acmc_pkg::MODE_LO] =
                acmc_pkg::MODE_NORMAL;
            s_next.phase = acmc_pkg::PH_CONV;
        end
        // write frames
        if (!tfsS && s_reg.prevTfsN && !s_reg.txAct) begin
            s_next.rxAct = 1'b1;
            s_next.bitCnt = 5'h00;
        end
        if (s_reg.rxAct && sclkS && !s_reg.prevSclk
                && s_reg.bitCnt < acmc_pkg::WORD_BITS) begin
            s_next.shift = {s_reg.shift[22:0], sdataS};
            s_next.bitCnt = s_reg.bitCnt + 5'h01;
        end
        if (s_reg.rxAct && tfsS && !s_reg.prevTfsN) begin
            s_next.rxAct = 1'b0;
            if (s_reg.bitCnt == acmc_pkg::WORD_BITS) begin
                ctrlLoad = !selS;
                coefLoad = selS && mode[2] && mode[1];
            end
        end
        if (ctrlLoad) begin
            s_next.ctrl = s_reg.shift;
            s_next.phase = startPhase(newMode);
            s_next.bgSlot = 3'h0;
            if (startPhase(newMode) != acmc_pkg::PH_CONV) begin
                s_next.readyN = 1'b1;
                // a result landing as a cal starts is stale, drop it
                publish = 1'b0;
            end
        end
        if (coefLoad && mode[0]) begin
            s_next.fullCoef[ch] = s_reg.shift;
        end else if (coefLoad) begin
            s_next.zeroCoef[ch] = s_reg.shift;
        end
        // read frames
        if (!rfsS && s_reg.prevRfsN && !s_reg.rxAct) begin
            s_next.txAct = 1'b1;
            s_next.bitCnt = 5'h00;
            s_next.txLen = acmc_pkg::WORD_BITS;
            s_next.txData = 1'b0;
            if (!selS) begin
                s_next.shift = s_reg.ctrl;
            end else if (mode == acmc_pkg::MODE_RW_ZERO) begin
                s_next.shift = s_reg.zeroCoef[ch];
            end else if (mode == acmc_pkg::MODE_RW_FULL) begin
                s_next.shift = s_reg.fullCoef[ch];
            end else begin
                s_next.shift = s_reg.dataOut;
                s_next.txData = 1'b1;
                if (!s_reg.ctrl[acmc_pkg::WL_BIT]) begin
                    s_next.txLen = acmc_pkg::SHORT_BITS;
                end
            end
        end else if (s_reg.txAct && !sclkS && s_reg.prevSclk
                && s_reg.bitCnt < s_reg.txLen) begin
            s_next.shift = {s_reg.shift[22:0], 1'b0};
            s_next.bitCnt = s_reg.bitCnt + 5'h01;
            txDone = s_reg.txData && (s_next.bitCnt == s_reg.txLen);
        end
        if (s_reg.txAct && rfsS && !s_reg.prevRfsN) begin
            s_next.txAct = 1'b0;
        end
        if (txDone) begin
            s_next.readyN = 1'b1;
        end
        if (publish) begin
            s_next.dataOut = measData;
            s_next.readyN = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
            s_reg.ctrl <= acmc_pkg::CTRL_RESET;
            s_reg.zeroCoef <= {2{acmc_pkg::COEF_RESET}};
            s_reg.fullCoef <= {2{acmc_pkg::COEF_RESET}};
            s_reg.readyN <= 1'b1;
            s_reg.phase <= acmc_pkg::PH_CONV;
            s_reg.prevSclk <= acmc_pkg::PIN_RESET[4];
            s_reg.prevTfsN <= acmc_pkg::PIN_RESET[2];
            s_reg.prevRfsN <= acmc_pkg::PIN_RESET[1];
        end else begin
            s_reg <= s_next;
        end
    end

    assign sdataOut = s_reg.shift[23];
    assign sdataOeN = ~s_reg.txAct;
    assign dataReadyN = s_reg.readyN;
    assign measSrc = srcFor(s_reg.phase, mode, s_reg.bgSlot);
    assign measChannel = ch;
    assign ctrlWord = s_reg.ctrl;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    short_write_a: assert property (!$past(ctrlLoad) && !$past(calDone)
        |-> $stable(s_reg.ctrl)) else $error("control word changed");
    cal_clears_a: assert property (calDone && !ctrlLoad
        |=> mode == acmc_pkg::MODE_NORMAL
        && s_reg.phase == acmc_pkg::PH_CONV) else $error("mode kept");
    cal_ready_a: assert property (s_reg.phase != acmc_pkg::PH_CONV
        |-> dataReadyN) else $error("ready low in cal");
    self_src_a: assert property (mode == acmc_pkg::MODE_SELF
        && s_reg.phase == acmc_pkg::PH_ZERO |-> measSrc == acmc_pkg::SRC_SHORT)
        else $error("self zero source");
    sys_zero_a: assert property (mode == acmc_pkg::MODE_SYS_ZERO
        && measValid && s_reg.phase == acmc_pkg::PH_ZERO && !ctrlLoad
        |=> mode == 3'h0
        && s_reg.zeroCoef[ch] == $past(measData))
        else $error("system zero step");
    sys_full_a: assert property (mode == acmc_pkg::MODE_SYS_FULL
        && s_reg.phase == acmc_pkg::PH_FULL |-> measSrc == acmc_pkg::SRC_INPUT)
        else $error("system full source");
    offset_full_a: assert property (mode == acmc_pkg::MODE_OFFSET
        && s_reg.phase == acmc_pkg::PH_FULL |-> measSrc == acmc_pkg::SRC_REF)
        else $error("offset full source");
    bg_rate_a: assert property (publish && mode == acmc_pkg::MODE_BACKGROUND
        |-> s_reg.bgSlot == 3'h5 && measSrc == acmc_pkg::SRC_INPUT)
        else $error("background rate");
    zero_write_a: assert property (coefLoad && mode == acmc_pkg::MODE_RW_ZERO
        |=> s_reg.zeroCoef[ch] == $past(s_reg.shift))
        else $error("zero coefficient write");
    publish_a: assert property (publish |=> !dataReadyN
        && s_reg.dataOut == $past(measData)) else $error("no publish");
    ready_return_a: assert property (txDone && !publish |=> dataReadyN)
        else $error("ready not returned");

    self_cal_c: cover property (calDone && mode == acmc_pkg::MODE_SELF);
    bg_word_c: cover property (publish && mode == acmc_pkg::MODE_BACKGROUND);
    coef_write_c: cover property (coefLoad);
    data_read_c: cover property (txDone);
endmodule // acmc_control
`default_nettype wire

// File: acmc_pkg.sv
// constants for the converter mode decoder and calibration sequencer
// assumes one 100 MHz clock; serial pins arrive unsynchronised
package acmc_pkg;
    localparam int CTRL_W = 24;
    localparam int MODE_HI = 23;
    localparam int MODE_LO = 21;
    localparam int CH_BIT = 17;
    localparam int WL_BIT = 15;
    localparam logic [23:0] CTRL_RESET = 24'h000000;
    localparam logic [23:0] COEF_RESET = 24'h000000;
    localparam logic [4:0] WORD_BITS = 5'h18;
    localparam logic [4:0] SHORT_BITS = 5'h10;
    localparam logic [2:0] BG_LAST = 3'h5;
    localparam logic [4:0] PIN_RESET = 5'h06;
    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_SELF = 3'h1;
    localparam logic [2:0] MODE_SYS_ZERO = 3'h2;
    localparam logic [2:0] MODE_SYS_FULL = 3'h3;
    localparam logic [2:0] MODE_OFFSET = 3'h4;
    localparam logic [2:0] MODE_BACKGROUND = 3'h5;
    localparam logic [2:0] MODE_RW_ZERO = 3'h6;
    localparam logic [2:0] MODE_RW_FULL = 3'h7;
    typedef enum logic [1:0] {SRC_INPUT, SRC_SHORT, SRC_REF} acmc_src_t;
    typedef enum logic [1:0] {PH_CONV, PH_ZERO, PH_FULL} acmc_phase_t;
endpackage

// File: acmc_pin_sync.sv
// three-stage synchroniser; a bit changes once stages two and three agree
// assumes inputs are asynchronous pins
`timescale 1ns/1ns
`default_nettype none
module acmc_pin_sync #(
    parameter int W = 5,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk, // system clock
    input wire logic rst, // async reset, high
    input wire logic [W-1:0] pinIn, // raw pins
    output logic [W-1:0] pinStable // filtered levels
);
    typedef struct packed {
        logic [W-1:0] ff1;
        logic [W-1:0] ff2;
        logic [W-1:0] ff3;
        logic [W-1:0] level;
    } acmc_sync_t;
    acmc_sync_t s_reg, s_next;

    always_comb begin
        s_next = s_reg;
        s_next.ff1 = pinIn;
        s_next.ff2 = s_reg.ff1;
        s_next.ff3 = s_reg.ff2;
        for (int i = 0; i < W; i++) begin
            if (s_reg.ff2[i] == s_reg.ff3[i]) begin
                s_next.level[i] = s_reg.ff2[i];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg <= {4{RST_VAL}};
        end else begin
            s_reg <= s_next;
        end
    end

    assign pinStable = s_reg.level;
endmodule // acmc_pin_sync
`default_nettype wire

// File: acmc_host_model.sv
// host-side serial port model: frames, external clock, data both ways
// assumes the device filters pins over 3-4 clocks, so each level lasts 6
`timescale 1ns/1ns
`default_nettype none
module acmc_host_model (
    input wire logic clk, // system clock, paces the pins
    output logic sclk, // serial clock, still outside frames
    output logic sdataIn, // serial data to the device
    output logic txFrameSyncN, // write frame, low active
    output logic rxFrameSyncN, // read frame, low active
    output logic registerSelect, // low: control word, high: data/coef
    input wire logic sdataOut, // serial data from the device
    input wire logic sdataOeN // low while the device drives data
);
    initial begin
        sclk = 1'b0;
        sdataIn = 1'b0;
        txFrameSyncN = 1'b1;
        rxFrameSyncN = 1'b1;
        registerSelect = 1'b0;
    end

    task automatic halfBit();
        repeat (6) @(negedge clk);
    endtask

    // n bits, MSB first; a full word is 24 bits, a short data read is 16
    task automatic xfer(input logic rd, input logic sel, input int n,
                        input logic [31:0] wdata, output logic [23:0] rdata);
        rdata = 24'h000000;
        @(negedge clk);
        registerSelect = sel;
        halfBit();
        if (rd) rxFrameSyncN = 1'b0;
        else txFrameSyncN = 1'b0;
        halfBit();
        halfBit();
        for (int i = n - 1; i >= 0; i--) begin
            if (!rd) sdataIn = wdata[i];
            halfBit();
            sclk = 1'b1;
            if (rd) rdata = {rdata[22:0], sdataOut};
            halfBit();
            sclk = 1'b0;
        end
        halfBit();
        txFrameSyncN = 1'b1;
        rxFrameSyncN = 1'b1;
        // released data line must not keep looking valid
        sdataIn = ~sdataIn;
        halfBit();
        halfBit();
    endtask
endmodule // acmc_host_model
`default_nettype wire

// File: adc_mode_calibration_control_tb.sv
// self-checking bench for the mode decoder and calibration sequencer
// assumes acmc_pkg and acmc_host_model compiled first
`timescale 1ns/1ns
`default_nettype none
module adc_mode_calibration_control_tb;
    logic clk, rst, sclk, sdataIn, sdataOut, sdataOeN, txFrameSyncN;
    logic rxFrameSyncN, registerSelect, dataReadyN, measValid, measChannel;
    logic [23:0] measData, ctrlWord, rd, base, d;
    logic [23:0] q [6];
    acmc_pkg::acmc_src_t measSrc;
    logic [15:0] lf = 16'h0558;
    int errorCnt = 0;
    int samplesChecked = 0;

    acmc_control DUT (.clk(clk), .rst(rst), .sclk(sclk), .sdataIn(sdataIn),
        .sdataOut(sdataOut), .sdataOeN(sdataOeN),
        .txFrameSyncN(txFrameSyncN), .rxFrameSyncN(rxFrameSyncN),
        .registerSelect(registerSelect), .dataReadyN(dataReadyN),
        .measValid(measValid), .measData(measData), .measSrc(measSrc),
        .measChannel(measChannel), .ctrlWord(ctrlWord));
    acmc_host_model hm (.clk(clk), .sclk(sclk), .sdataIn(sdataIn),
        .txFrameSyncN(txFrameSyncN), .rxFrameSyncN(rxFrameSyncN),
        .registerSelect(registerSelect), .sdataOut(sdataOut),
        .sdataOeN(sdataOeN));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [23:0] rnd();
        for (int i = 0; i < 24; i++) begin
            lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
            rnd[i] = lf[0];
        end
    endfunction

    // word length kept at 16 bits, top filter bit kept clear
    function automatic logic [23:0] word(logic [2:0] m);
        return {m, base[20:16], 1'b0, base[14:12], 1'b0, base[10:0]};
    endfunction

    function automatic int steps(logic [2:0] m);
        if (m == acmc_pkg::MODE_BACKGROUND) return 6;
        if (m == acmc_pkg::MODE_SELF || m == acmc_pkg::MODE_OFFSET) return 2;
        return 1;
    endfunction

    function automatic acmc_pkg::acmc_src_t srcOf(logic [2:0] m, int s);
        if (m == acmc_pkg::MODE_SELF || m == acmc_pkg::MODE_BACKGROUND) begin
            if (s == 0) return acmc_pkg::SRC_SHORT;
            if (s == 1) return acmc_pkg::SRC_REF;
        end
        if (m == acmc_pkg::MODE_OFFSET && s == 1) return acmc_pkg::SRC_REF;
        return acmc_pkg::SRC_INPUT;
    endfunction

    task automatic chk(string nm, logic [23:0] seen, logic [23:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errorCnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic meas(logic [23:0] v);
        @(negedge clk);
        measValid = 1'b1;
        measData = v;
        @(negedge clk);
        measValid = 1'b0;
        measData = ~v;
        repeat (3) @(negedge clk);
    endtask

    task automatic wr(logic sel, int n, logic [31:0] v);
        hm.xfer(1'b0, sel, n, v, rd);
    endtask

    task automatic rdw(logic sel, int n);
        hm.xfer(1'b1, sel, n, 32'h00000000, rd);
    endtask

    task automatic wrap_up();
        if (errorCnt == 0 && samplesChecked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        errorCnt++;
        wrap_up();
    end

    initial begin
        rst = 1'b1;
        measValid = 1'b0;
        measData = 24'h000000;
        base = 24'h000000;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        repeat (6) @(negedge clk);
        chk("ctrlReset", ctrlWord, 24'h000000);
        chk("rdyReset", 24'(dataReadyN), 24'h000001);
        chk("srcReset", 24'(measSrc), 24'(acmc_pkg::SRC_INPUT));
        base = rnd();
        wr(1'b0, 24, 32'(word(3'h0)));
        chk("ctrlWrite", ctrlWord, word(3'h0));
        chk("channel", 24'(measChannel), 24'(base[17]));
        rdw(1'b0, 24);
        chk("ctrlRead", rd, word(3'h0));
        wr(1'b0, 16, 32'(rnd()));
        chk("shortCtrl", ctrlWord, word(3'h0));
        base = rnd();
        wr(1'b0, 26, {6'h00, word(3'h0), 2'h3});
        chk("longCtrl", ctrlWord, word(3'h0));
        d = rnd();
        meas(d);
        chk("rdyNew", 24'(dataReadyN), 24'h000000);
        rdw(1'b1, 16);
        chk("dataRead", rd, {8'h00, d[23:8]});
        chk("rdyShifted", 24'(dataReadyN), 24'h000001);
        chk("oeReleased", 24'(sdataOeN), 24'h000001);
        for (int m = 1; m <= 5; m++) begin
            wr(1'b0, 24, 32'(word(m[2:0])));
            for (int s = 0; s < steps(m[2:0]); s++) begin
                chk("calSrc", 24'(measSrc), 24'(srcOf(m[2:0], s)));
                chk("calRdyHigh", 24'(dataReadyN), 24'h000001);
                q[s] = rnd();
                meas(q[s]);
            end
            if (m < 5) begin
                chk("modeClear", 24'(ctrlWord[23:21]), 24'h000000);
                d = rnd();
                meas(d);
            end else begin
                d = q[5];
            end
            chk("calDone", 24'(dataReadyN), 24'h000000);
            rdw(1'b1, 16);
            chk("calData", rd, {8'h00, d[23:8]});
        end
        // coefficients filled by background slots, no host writes
        wr(1'b0, 24, 32'(word(3'h6)));
        rdw(1'b1, 24);
        chk("bgZero", rd, q[0]);
        wr(1'b0, 24, 32'(word(3'h7)));
        rdw(1'b1, 24);
        chk("bgFull", rd, q[1]);
        for (int m = 6; m <= 7; m++) begin
            wr(1'b0, 24, 32'(word(m[2:0])));
            d = rnd();
            wr(1'b1, 24, 32'(d));
            rdw(1'b1, 24);
            chk("coefRw", rd, d);
            wr(1'b1, 16, 32'(rnd()));
            rdw(1'b1, 24);
            chk("coefShort", rd, d);
        end
        // word-length bit set: data reads run the full 24 bits
        wr(1'b0, 24, 32'(word(3'h0) | 24'h008000));
        d = rnd();
        meas(d);
        rdw(1'b1, 24);
        chk("data24", rd, d);
        chk("rdy24", 24'(dataReadyN), 24'h000001);
        wrap_up();
    end
endmodule // adc_mode_calibration_control_tb
`default_nettype wire
